// [rtl/cell_counter_access_overflow_status.sv]
// overflow status registers and indirect statistics counter access
`default_nettype none
module cell_counter_access_overflow_status #(
    parameter int LINKS = 16,
    parameter int GROUPS = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // host register port
    input wire logic [11:0] cpu_addr_i,
    input wire logic [15:0] cpu_wdata_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    output logic [15:0] cpu_rdata_o,
    // overflow events, one-cycle pulses
    input wire logic [LINKS-1:0] rx_bad_icp_ovf_i,
    input wire logic [GROUPS-1:0] grp_fifo_ovf_i,
    input wire logic [GROUPS-1:0] grp_all_ovf_i,
    input wire logic [GROUPS-1:0] grp_idle_ovf_i,
    input wire logic [GROUPS-1:0] grp_unas_ovf_i,
    input wire logic [GROUPS-1:0] grp_hec_ovf_i,
    // flags towards interrupt logic elsewhere
    output logic [LINKS-1:0] link_bad_icp_ovf_o,
    output logic [GROUPS*ovf_stat_pkg::GRP_FLAGS-1:0] group_ovf_o,
    // port to the counter store
    output logic cnt_req_o,
    output logic cnt_clear_o,
    output logic [1:0] cnt_op_o,
    output logic cnt_dir_o,
    output logic cnt_en_value_o,
    output logic [3:0] cnt_type_o,
    output logic [4:0] cnt_index_o,
    output logic [ovf_stat_pkg::CNT_W-1:0] cnt_wdata_o,
    input wire logic cnt_ack_i,
    input wire logic [ovf_stat_pkg::CNT_W-1:0] cnt_rdata_i
);
    localparam int GW = GROUPS * ovf_stat_pkg::GRP_FLAGS;

    // state of the bank apart from the sticky flags held in the flag banks
    typedef struct packed {
        ovf_stat_pkg::xfer_state_t st; // transfer engine
        logic [7:0] top; // counter byte 3
        logic [15:0] mid; // counter bytes 2 and 1
        logic [ovf_stat_pkg::SEL_W-1:0] sel; // type and index
        logic [1:0] op; // last command operation
        logic dir; // last command direction
        logic en_val; // enable bit value to transfer
        logic done; // transfer finished
        logic [15:0] rdata; // read answer
        logic req; // request pulse to counters
        logic clear; // clear-all pulse
    } regs_t;

    regs_t r;
    regs_t next_r;

    logic [LINKS-1:0] link_set; // link flag set vector
    logic [LINKS-1:0] link_clr; // link flag clear vector
    logic [GW-1:0] grp_set; // group flag set vector
    logic [GW-1:0] grp_clr; // group flag clear vector
    logic [LINKS-1:0] link_flags; // stored link flags
    logic [GW-1:0] grp_flags; // stored group flags
    logic link_hit; // access falls in the link bank
    logic grp_hit; // access falls in the group bank
    logic sel_ok; // select register holds a legal code

    // legal type/index pairs; group indexes only with input counters
    function automatic logic sel_valid(input logic [3:0] ctype, input logic [4:0] idx);
        logic ok;
        ok = 1'b0;
        if (ctype <= ovf_stat_pkg::TYPE_IN_ALL) begin
            if (idx >= ovf_stat_pkg::FIRST_LINK && idx <= ovf_stat_pkg::LAST_LINK) begin
                ok = 1'b1;
            end else if (idx >= ovf_stat_pkg::FIRST_GROUP && idx <= ovf_stat_pkg::LAST_GROUP
                         && ctype >= ovf_stat_pkg::TYPE_IN_HEC) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    // address decode of the two banks
    assign link_hit = (cpu_addr_i[11:4] == ovf_stat_pkg::LINK_PAGE);
    assign grp_hit = (cpu_addr_i[11:3] == ovf_stat_pkg::GROUP_PAGE);
    assign sel_ok = sel_valid(r.sel[ovf_stat_pkg::SEL_TYPE_MSB:ovf_stat_pkg::SEL_TYPE_LSB],
                              r.sel[ovf_stat_pkg::SEL_INDEX_MSB:0]);

    assign link_set = rx_bad_icp_ovf_i;

    // event routing into per-group flag slices
    always_comb begin
        grp_set = '0;
        for (int g = 0; g < GROUPS; g++) begin
            grp_set[g*ovf_stat_pkg::GRP_FLAGS + ovf_stat_pkg::GRP_FIFO_BIT] = grp_fifo_ovf_i[g];
            grp_set[g*ovf_stat_pkg::GRP_FLAGS + ovf_stat_pkg::GRP_ALL_BIT] = grp_all_ovf_i[g];
            grp_set[g*ovf_stat_pkg::GRP_FLAGS + ovf_stat_pkg::GRP_IDLE_BIT] = grp_idle_ovf_i[g];
            grp_set[g*ovf_stat_pkg::GRP_FLAGS + ovf_stat_pkg::GRP_UNAS_BIT] = grp_unas_ovf_i[g];
            grp_set[g*ovf_stat_pkg::GRP_FLAGS + ovf_stat_pkg::GRP_HEC_BIT] = grp_hec_ovf_i[g];
        end
    end

    // sticky link flags
    ovf_flag_bank #(.W(LINKS)) u_link_flags (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .set_i(link_set),
        .clr_i(link_clr),
        .flags_o(link_flags)
    );

    // sticky group flags, five per group
    ovf_flag_bank #(.W(GW)) u_group_flags (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .set_i(grp_set),
        .clr_i(grp_clr),
        .flags_o(grp_flags)
    );

    // register writes, read mux and transfer engine
    always_comb begin
        logic [15:0] rd_val;
        int li;
        int gi;
        rd_val = '0;
        li = int'(cpu_addr_i[3:0]);
        gi = int'(cpu_addr_i[2:0]) * ovf_stat_pkg::GRP_FLAGS;
        next_r = r;
        next_r.req = 1'b0;
        next_r.clear = 1'b0;
        link_clr = '0;
        grp_clr = '0;

        // host writes
        if (cpu_wr_i) begin
            if (cpu_addr_i == ovf_stat_pkg::TOP_STAGE_ADDR) begin
                next_r.top = cpu_wdata_i[7:0];
            end else if (cpu_addr_i == ovf_stat_pkg::MID_STAGE_ADDR) begin
                next_r.mid = cpu_wdata_i;
            end else if (cpu_addr_i == ovf_stat_pkg::SEL_ADDR) begin
                next_r.sel = cpu_wdata_i[ovf_stat_pkg::SEL_W-1:0];
            end else if (cpu_addr_i == ovf_stat_pkg::CMD_ADDR) begin
                // a command while one is pending is ignored
                if (r.st == ovf_stat_pkg::ST_IDLE) begin
                    next_r.op = cpu_wdata_i[1:0];
                    next_r.dir = cpu_wdata_i[ovf_stat_pkg::CMD_DIR_BIT];
                    next_r.en_val = cpu_wdata_i[ovf_stat_pkg::CMD_ENV_BIT];
                    if (cpu_wdata_i[1:0] == ovf_stat_pkg::OP_CLEAR) begin
                        next_r.clear = 1'b1;
                        next_r.done = 1'b1;
                    end else if (cpu_wdata_i[1:0] == ovf_stat_pkg::OP_COUNTER
                                 || cpu_wdata_i[1:0] == ovf_stat_pkg::OP_IRQ_EN) begin
                        // illegal select finishes at once, nothing moves
                        if (sel_ok) begin
                            next_r.req = 1'b1;
                            next_r.done = 1'b0;
                            next_r.st = ovf_stat_pkg::ST_WAIT;
                        end else begin
                            next_r.done = 1'b1;
                        end
                    end
                end
            end else if (link_hit && li < LINKS) begin
                link_clr[li] = ~cpu_wdata_i[ovf_stat_pkg::LINK_BAD_ICP_BIT];
            end else if (grp_hit && gi < GW) begin
                grp_clr[gi +: ovf_stat_pkg::GRP_FLAGS] = ~cpu_wdata_i[4:0];
            end
        end

        // transfer completion; the counter answer wins over a staging write
        unique case (r.st)
            ovf_stat_pkg::ST_IDLE: begin
                next_r.st = next_r.st;
            end
            ovf_stat_pkg::ST_WAIT: begin
                if (cnt_ack_i) begin
                    // counter to host loads both stages
                    if (r.dir == ovf_stat_pkg::DIR_TO_HOST
                        && r.op == ovf_stat_pkg::OP_COUNTER) begin
                        next_r.top = cnt_rdata_i[23:16];
                        next_r.mid = cnt_rdata_i[15:0];
                    end
                    next_r.done = 1'b1;
                    next_r.st = ovf_stat_pkg::ST_IDLE;
                end
            end
            default: begin
                next_r.st = ovf_stat_pkg::ST_IDLE;
            end
        endcase

        // read mux; unmapped addresses read zero
        if (cpu_addr_i == ovf_stat_pkg::TOP_STAGE_ADDR) begin
            rd_val = {8'h00, r.top};
        end else if (cpu_addr_i == ovf_stat_pkg::MID_STAGE_ADDR) begin
            rd_val = r.mid;
        end else if (cpu_addr_i == ovf_stat_pkg::SEL_ADDR) begin
            rd_val = {7'h00, r.sel};
        end else if (cpu_addr_i == ovf_stat_pkg::CMD_ADDR) begin
            rd_val = {8'h00, r.done, 3'h0, r.en_val, r.dir, r.op};
        end else if (link_hit && li < LINKS) begin
            rd_val = {15'h0000, link_flags[li]};
        end else if (grp_hit && gi < GW) begin
            rd_val = {11'h000, grp_flags[gi +: ovf_stat_pkg::GRP_FLAGS]};
        end
        if (cpu_rd_i) begin
            next_r.rdata = rd_val;
        end
    end

    // state register with documented reset values
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r.st <= ovf_stat_pkg::ST_IDLE;
            r.top <= ovf_stat_pkg::STAGE_RESET[7:0];
            r.mid <= ovf_stat_pkg::STAGE_RESET;
            r.sel <= ovf_stat_pkg::SEL_RESET[ovf_stat_pkg::SEL_W-1:0];
            r.op <= ovf_stat_pkg::CMD_RESET[1:0];
            r.dir <= ovf_stat_pkg::CMD_RESET[ovf_stat_pkg::CMD_DIR_BIT];
            r.en_val <= ovf_stat_pkg::CMD_RESET[ovf_stat_pkg::CMD_ENV_BIT];
            r.done <= ovf_stat_pkg::CMD_RESET[ovf_stat_pkg::CMD_DONE_BIT];
            r.rdata <= '0;
            r.req <= 1'b0;
            r.clear <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flops
    assign cpu_rdata_o = r.rdata;
    assign link_bad_icp_ovf_o = link_flags;
    assign group_ovf_o = grp_flags;
    assign cnt_req_o = r.req;
    assign cnt_clear_o = r.clear;
    assign cnt_op_o = r.op;
    assign cnt_dir_o = r.dir;
    assign cnt_en_value_o = r.en_val;
    // type code driven to counter store
    assign cnt_type_o = r.sel[ovf_stat_pkg::SEL_TYPE_MSB:ovf_stat_pkg::SEL_TYPE_LSB];
    assign cnt_index_o = r.sel[ovf_stat_pkg::SEL_INDEX_MSB:0];
    assign cnt_wdata_o = {r.top, r.mid};

    a_link_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rx_bad_icp_ovf_i != '0)
        |=> ((link_bad_icp_ovf_o & $past(rx_bad_icp_ovf_i)) == $past(rx_bad_icp_ovf_i)))
        else $error("link overflow flag not set");

    a_group_read_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cpu_rd_i && grp_hit) |=> (cpu_rdata_o[15:5] == 11'h000))
        else $error("group status upper bits not zero");

    a_top_stage_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cpu_rd_i && cpu_addr_i == ovf_stat_pkg::TOP_STAGE_ADDR)
        |=> (cpu_rdata_o == {8'h00, $past(cnt_wdata_o[23:16])}))
        else $error("top stage read wrong");

    a_mid_stage_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cpu_rd_i && cpu_addr_i == ovf_stat_pkg::MID_STAGE_ADDR)
        |=> (cpu_rdata_o == $past(cnt_wdata_o[15:0])))
        else $error("middle stage read wrong");

    a_stage_write_held: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cpu_wr_i && cpu_addr_i == ovf_stat_pkg::MID_STAGE_ADDR && !cnt_ack_i)
        |=> (!cnt_req_o && cnt_wdata_o[15:0] == $past(cpu_wdata_i)))
        else $error("staging write not simply held");

    a_clear_command: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cpu_wr_i && cpu_addr_i == ovf_stat_pkg::CMD_ADDR && r.st == ovf_stat_pkg::ST_IDLE
         && cpu_wdata_i[1:0] == ovf_stat_pkg::OP_CLEAR)
        |=> (cnt_clear_o && !cnt_req_o) ##1 !cnt_clear_o)
        else $error("clear command not a single pulse");

    a_select_legal: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cnt_req_o |-> sel_valid(cnt_type_o, cnt_index_o))
        else $error("request issued for illegal select");

    a_load_to_host: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (r.st == ovf_stat_pkg::ST_WAIT && cnt_ack_i && r.dir == ovf_stat_pkg::DIR_TO_HOST
         && r.op == ovf_stat_pkg::OP_COUNTER)
        |=> (cnt_wdata_o == $past(cnt_rdata_i)))
        else $error("counter value not loaded into stages");

    a_done_tracks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cnt_req_o |-> (!r.done throughout (r.st == ovf_stat_pkg::ST_WAIT)[*1]))
        else $error("done set while transfer pending");

    a_done_on_ack: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (r.st == ovf_stat_pkg::ST_WAIT && cnt_ack_i) |=> (r.done && r.st == ovf_stat_pkg::ST_IDLE))
        else $error("done not raised after counter answer");
endmodule
`default_nettype wire

// [rtl/ovf_stat_pkg.sv]
// constants for the overflow status and counter access register bank
`default_nettype none
package ovf_stat_pkg;
    // host bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    // statistics counter width, bytes 3..1
    localparam int CNT_W = 24;

    // register addresses (host word addresses)
    localparam logic [11:0] CMD_ADDR = 12'h40F;
    localparam logic [11:0] LINK_OVF_BASE = 12'h410;
    localparam logic [11:0] GROUP_OVF_BASE = 12'h420;
    localparam logic [11:0] TOP_STAGE_ADDR = 12'h430;
    localparam logic [11:0] MID_STAGE_ADDR = 12'h431;
    localparam logic [11:0] SEL_ADDR = 12'h432;
    // pages used to decode the per-link and per-group banks
    localparam logic [7:0] LINK_PAGE = 8'h41;
    localparam logic [8:0] GROUP_PAGE = 9'h084;

    // reset values
    localparam logic [15:0] CMD_RESET = 16'h0080;
    localparam logic [15:0] STAGE_RESET = 16'h0000;
    localparam logic [15:0] SEL_RESET = 16'h0000;

    // select register fields
    localparam int SEL_W = 9;
    localparam int SEL_TYPE_LSB = 5;
    localparam int SEL_TYPE_MSB = 8;
    localparam int SEL_INDEX_MSB = 4;
    localparam int INDEX_GROUP_BIT = 4;

    // command register fields
    localparam int CMD_DONE_BIT = 7;
    localparam int CMD_ENV_BIT = 3;
    localparam int CMD_DIR_BIT = 2;

    // command operations
    localparam logic [1:0] OP_CLEAR = 2'h0;
    localparam logic [1:0] OP_COUNTER = 2'h1;
    localparam logic [1:0] OP_IRQ_EN = 2'h2;
    // transfer directions
    localparam logic DIR_TO_COUNTER = 1'b0;
    localparam logic DIR_TO_HOST = 1'b1;

    // counter type codes
    localparam logic [3:0] TYPE_IN_ALL = 4'hB;
    localparam logic [3:0] TYPE_IN_IDLE = 4'hA;
    localparam logic [3:0] TYPE_IN_UNAS = 4'h9;
    localparam logic [3:0] TYPE_IN_HEC = 4'h8;
    localparam logic [3:0] TYPE_TX_ALL = 4'h7;
    localparam logic [3:0] TYPE_TX_IDLE = 4'h6;
    localparam logic [3:0] TYPE_TX_STUFF = 4'h5;
    localparam logic [3:0] TYPE_TX_ICP = 4'h4;
    localparam logic [3:0] TYPE_RX_ALL = 4'h3;
    localparam logic [3:0] TYPE_RX_IDLE = 4'h2;
    localparam logic [3:0] TYPE_RX_HEC = 4'h1;
    localparam logic [3:0] TYPE_RX_BAD_ICP = 4'h0;

    // index codes
    localparam logic [4:0] FIRST_LINK = 5'h00;
    localparam logic [4:0] LAST_LINK = 5'h0F;
    localparam logic [4:0] FIRST_GROUP = 5'h10;
    localparam logic [4:0] LAST_GROUP = 5'h17;

    // group overflow bit positions
    localparam int GRP_FLAGS = 5;
    localparam int GRP_FIFO_BIT = 4;
    localparam int GRP_ALL_BIT = 3;
    localparam int GRP_IDLE_BIT = 2;
    localparam int GRP_UNAS_BIT = 1;
    localparam int GRP_HEC_BIT = 0;
    // link overflow bit position
    localparam int LINK_BAD_ICP_BIT = 0;

    // transfer engine states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } xfer_state_t;
endpackage
`default_nettype wire

// [rtl/ovf_flag_bank.sv]
// bank of sticky overflow flags, set by hardware, cleared by host
`default_nettype none
module ovf_flag_bank #(
    parameter int W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flags_o
);
    // whole state of the bank
    typedef struct packed {
        logic [W-1:0] flags;
    } bank_t;

    bank_t r;
    bank_t next_r;

    // set wins over clear so an overflow in the clear cycle is kept
    always_comb begin
        next_r = r;
        next_r.flags = (r.flags & ~clr_i) | set_i;
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign flags_o = r.flags;

    // an overflow always lands in its flag, even against a clear
    a_set_wins_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i)))
        else $error("overflow event lost against clear");

    // a clear without an event empties the flag next cycle
    a_clear_works: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (clr_i != '0) |=> ((flags_o & $past(clr_i) & ~$past(set_i)) == '0))
        else $error("flag not cleared by host write");
endmodule
`default_nettype wire

// [dv/counter_store_model.sv]
// behavioural counter store on the far side of the counter port
`default_nettype none
module counter_store_model (
    input wire logic clk_sys_i,
    input wire logic slow_i,
    input wire logic cnt_req_i,
    input wire logic cnt_clear_i,
    input wire logic cnt_dir_i,
    input wire logic [3:0] cnt_type_i,
    input wire logic [4:0] cnt_index_i,
    input wire logic [23:0] cnt_wdata_i,
    output logic cnt_ack_o,
    output logic [23:0] cnt_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // 24-bit counters, keyed by type and index
    logic [23:0] mem [0:511];
    logic [8:0] key;
    initial begin
        cnt_ack_o = 1'b0;
        cnt_rdata_o = 24'h5A5A5A;
        foreach (mem[i]) mem[i] = 24'h000000;
        forever begin
            @(posedge clk_sys_i);
            if (cnt_clear_i) begin
                foreach (mem[i]) mem[i] = 24'h000000;
            end
            if (cnt_req_i) begin
                key = {cnt_type_i, cnt_index_i};
                // slow answers let the pending state be seen
                repeat (slow_i ? 4 : 1) @(posedge clk_sys_i);
                #1;
                cnt_ack_o = 1'b1;
                cnt_rdata_o = mem[key];
                // direction 0 moves staged data in
                if (!cnt_dir_i) mem[key] = cnt_wdata_i;
                @(posedge clk_sys_i);
                #1;
                cnt_ack_o = 1'b0;
                // stale data is not left on the bus
                cnt_rdata_o = ~cnt_rdata_o;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/test_cell_counter_access_overflow_status.sv]
// self-checking bench for the overflow status and counter access bank
`default_nettype none
module test_cell_counter_access_overflow_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, rst_n_i, cpu_wr_i, cpu_rd_i, slow;
    logic cnt_req, cnt_clear, cnt_dir, cnt_en, cnt_ack;
    logic [11:0] cpu_addr;
    logic [15:0] cpu_wdata, cpu_rdata, d;
    logic [15:0] link_pulse, link_flags;
    logic [7:0] grp_ovf [5];
    logic [39:0] group_flags;
    logic [1:0] cnt_op;
    logic [3:0] cnt_type;
    logic [4:0] cnt_index, ix;
    logic [23:0] cnt_wdata, cnt_rdata, val;
    int err_count, n_checks, cycles, l, g;
    // registers read back after reset; the last one is unmapped
    logic [11:0] reset_addrs [7] = '{12'h40F, 12'h410, 12'h420, 12'h430, 12'h431, 12'h432, 12'h500};
    cell_counter_access_overflow_status cell_counter_access_overflow_status_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_addr_i(cpu_addr),
        .cpu_wdata_i(cpu_wdata), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
        .cpu_rdata_o(cpu_rdata), .rx_bad_icp_ovf_i(link_pulse), .grp_fifo_ovf_i(grp_ovf[4]),
        .grp_all_ovf_i(grp_ovf[3]), .grp_idle_ovf_i(grp_ovf[2]), .grp_unas_ovf_i(grp_ovf[1]),
        .grp_hec_ovf_i(grp_ovf[0]), .link_bad_icp_ovf_o(link_flags), .group_ovf_o(group_flags),
        .cnt_req_o(cnt_req), .cnt_clear_o(cnt_clear), .cnt_op_o(cnt_op), .cnt_dir_o(cnt_dir),
        .cnt_en_value_o(cnt_en), .cnt_type_o(cnt_type), .cnt_index_o(cnt_index),
        .cnt_wdata_o(cnt_wdata), .cnt_ack_i(cnt_ack), .cnt_rdata_i(cnt_rdata));
    counter_store_model counter_store_model_inst (
        .clk_sys_i(clk_sys_i), .slow_i(slow), .cnt_req_i(cnt_req), .cnt_clear_i(cnt_clear),
        .cnt_dir_i(cnt_dir), .cnt_type_i(cnt_type), .cnt_index_i(cnt_index),
        .cnt_wdata_i(cnt_wdata), .cnt_ack_o(cnt_ack), .cnt_rdata_o(cnt_rdata));
    // clock never stops
    // 100 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // hang guard, well above the run length
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle strobe, then an idle cycle so strobes never merge
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        cpu_addr = a;
        cpu_wdata = v;
        cpu_wr_i = 1'b1;
        @(posedge clk_sys_i);
        #1 cpu_wr_i = 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [15:0] v);
        cpu_addr = a;
        cpu_rd_i = 1'b1;
        @(posedge clk_sys_i);
        #1 cpu_rd_i = 1'b0;
        @(posedge clk_sys_i);
        #1 v = cpu_rdata;
    endtask
    // issue a command and poll done; first poll comes back in f
    task automatic xfer(input logic [8:0] sel, input logic [15:0] cmd, output logic [15:0] f);
        logic [15:0] p;
        wr(ovf_stat_pkg::SEL_ADDR, {7'h00, sel});
        wr(ovf_stat_pkg::CMD_ADDR, cmd);
        rd(ovf_stat_pkg::CMD_ADDR, f);
        p = f;
        for (int i = 0; i < 20 && p[7] !== 1'b1; i++) rd(ovf_stat_pkg::CMD_ADDR, p);
        chk("done bit", 24'h1, {23'h0, p[7]});
    endtask
    task automatic pulse(input logic [15:0] lp, input int b, input logic [7:0] gp);
        link_pulse = lp;
        grp_ovf[b] = gp;
        @(posedge clk_sys_i);
        #1 link_pulse = 16'h0000;
        grp_ovf[b] = 8'h00;
        @(posedge clk_sys_i);
        #1;
    endtask
    initial begin
        {cpu_wr_i, cpu_rd_i, slow, cpu_addr, cpu_wdata, link_pulse} = '0;
        foreach (grp_ovf[i]) grp_ovf[i] = 8'h00;
        rst_n_i = 1'b0;
        void'($urandom(32'h84CE));
        repeat (4) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        // reset values, command reads done, unmapped reads zero
        foreach (reset_addrs[i]) begin
            rd(reset_addrs[i], d);
            chk("reset value", (i == 0) ? 24'h80 : 24'h0, {8'h00, d});
        end
        // link flag set, held, cleared by writing 0
        for (int k = 0; k < 4; k++) begin
            l = (k == 0) ? 15 : $urandom_range(15);
            pulse(16'h0001 << l, 0, 8'h00);
            chk("link flag", 24'h1, {23'h0, link_flags[l]});
            rd(ovf_stat_pkg::LINK_OVF_BASE + 12'(l), d);
            chk("link reg", 24'h1, {8'h00, d});
            wr(ovf_stat_pkg::LINK_OVF_BASE + 12'(l), 16'h0000);
            rd(ovf_stat_pkg::LINK_OVF_BASE + 12'(l), d);
            chk("link clear", 24'h0, {8'h00, d});
        end
        // every group flag bit, unused bits read zero, write 1 keeps
        for (int b = 0; b < 5; b++) begin
            g = (b == 4) ? 7 : $urandom_range(7);
            pulse(16'h0000, b, 8'h01 << g);
            chk("group flag", 24'h1, {23'h0, group_flags[5*g+b]});
            wr(ovf_stat_pkg::GROUP_OVF_BASE + 12'(g), 16'hFFFF);
            rd(ovf_stat_pkg::GROUP_OVF_BASE + 12'(g), d);
            chk("group reg", 24'h1 << b, {8'h00, d});
            wr(ovf_stat_pkg::GROUP_OVF_BASE + 12'(g), 16'h0000);
            rd(ovf_stat_pkg::GROUP_OVF_BASE + 12'(g), d);
            chk("group clear", 24'h0, {8'h00, d});
        end
        // every counter type, link and group indices, both directions
        for (int t = 0; t < 12; t++) begin
            ix = (t == 0) ? 5'h0F : 5'($urandom_range(15));
            if (t >= 8) ix = (t == 11) ? 5'h17 : (t == 8) ? 5'h10 : 5'h10 + 5'($urandom_range(7));
            val = 24'($urandom);
            slow = t[0];
            wr(ovf_stat_pkg::TOP_STAGE_ADDR, {8'($urandom), val[23:16]});
            wr(ovf_stat_pkg::MID_STAGE_ADDR, val[15:0]);
            chk("held", 24'h0, counter_store_model_inst.mem[{t[3:0], ix}]);
            xfer({t[3:0], ix}, 16'h0001, d);
            chk("pending", 24'h0, {23'h0, d[7]});
            chk("stored", val, counter_store_model_inst.mem[{t[3:0], ix}]);
            wr(ovf_stat_pkg::MID_STAGE_ADDR, ~val[15:0]);
            xfer({t[3:0], ix}, 16'h0005, d);
            rd(ovf_stat_pkg::TOP_STAGE_ADDR, d);
            chk("top stage", {16'h0, val[23:16]}, {8'h00, d});
            rd(ovf_stat_pkg::MID_STAGE_ADDR, d);
            chk("mid stage", {8'h0, val[15:0]}, {8'h00, d});
            rd(ovf_stat_pkg::SEL_ADDR, d);
            chk("select", {15'h0, t[3:0], ix}, {8'h00, d});
        end
        // enable-bit transfer drives op and value
        xfer({4'hB, 5'h12}, 16'h000A, d);
        chk("op", 24'h2, {22'h0, cnt_op});
        chk("enable value", 24'h1, {23'h0, cnt_en});
        // clear all, then read a counter back as zero
        wr(ovf_stat_pkg::CMD_ADDR, 16'h0000);
        xfer({4'hB, 5'h17}, 16'h0005, d);
        rd(ovf_stat_pkg::MID_STAGE_ADDR, d);
        chk("cleared", 24'h0, {8'h00, d});
        wrap_up();
    end
endmodule
`default_nettype wire
